// ==== design/line_supervision_control.sv ====
`timescale 1ns/100ps
// Function
// RULE_01 - overhead bit widens range to 13.5 V
// RULE_02 - manual battery bit follows high battery
// RULE_03 - tracking bit: floor at low or track ring
// RULE_04 - common-mode manual forces programmed common mode
// RULE_05 - differential manual forces on-hook voltage
// RULE_06 - speed-up bit enables automatic speed-up
// RULE_07 - auto battery picks low battery off-hook
// RULE_08 - auto ring trip moves line active
// RULE_09 - auto loop closure moves line active
// RULE_10 - auto power alarm opens the line
// RULE_11 - raw bit low while threshold exceeded
// RULE_12 - ring trip filtered bit after debounce
// RULE_13 - loop closure filtered bit; status resets zero
// RULE_14 - filtered change only after steady interval
// RULE_15 - loop closure interval 1.25 ms steps
// RULE_16 - ring trip interval 1.25 ms, reset 0x0a
// RULE_17 - current code 20 mA plus 3 mA steps
// RULE_18 - automatic targets: open 000, forward 001
// RULE_19 - reserved bits ignore writes, read zero
// RULE_20 - status reads have no side effect
module line_supervision_control #(
  parameter int ADDR_WIDTH = 12,
  parameter int STEP_CYCLES = line_supervision_pkg::DEBOUNCE_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_detect_n,
  input wire logic [2:0] linefeed_state_code,
  input wire logic power_alarm,
  output logic overhead_range_select,
  output logic [7:0] overhead_max_dv,
  output logic battery_manual_set,
  output logic battery_track_ring,
  output logic common_mode_manual,
  output logic differential_manual,
  output logic speedup_enable,
  output logic battery_low_select,
  output logic ring_trip_filtered,
  output logic loop_closure_filtered,
  output logic [6:0] loop_closure_debounce_time,
  output logic [6:0] ring_trip_debounce_time,
  output logic [2:0] loop_current_code,
  output logic [5:0] loop_current_ma,
  output logic linefeed_req,
  output logic [2:0] linefeed_req_code
);

  logic [7:0] battery_feed_control_r;
  logic [7:0] auto_manual_control_r;
  logic [6:0] loop_closure_debounce_r;
  logic [6:0] ring_trip_debounce_r;
  logic [2:0] loop_current_limit_r;
  logic raw_detect_r;
  logic [7:0] detect_status;
  logic [7:0] reg_index;
  logic addr_ok;
  logic wr_en;
  logic rd_setup;
  logic [7:0] rd_value;
  logic ringing;
  logic detected;

  function automatic logic [7:0] byte_index(input logic [ADDR_WIDTH-1:0] addr);
    logic [ADDR_WIDTH-1:0] idx;
    idx = addr >> 2;
    return idx[7:0];
  endfunction

  assign reg_index = byte_index(paddr);
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_WIDTH-1:10] == '0)
    && (reg_index >= line_supervision_pkg::BATTERY_FEED_CONTROL_IDX)
    && (reg_index <= line_supervision_pkg::LOOP_CURRENT_LIMIT_IDX);
  assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_setup = psel && !penable && !pwrite;

  // zero wait states; unmapped or misaligned addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // writable registers; reserved bits are masked off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      battery_feed_control_r <= line_supervision_pkg::BATTERY_FEED_CONTROL_RESET;
      auto_manual_control_r <= line_supervision_pkg::AUTO_MANUAL_CONTROL_RESET;
      loop_closure_debounce_r <= line_supervision_pkg::LOOP_CLOSURE_DEBOUNCE_RESET; // RULE_15
      ring_trip_debounce_r <= line_supervision_pkg::RING_TRIP_DEBOUNCE_RESET; // RULE_16
      loop_current_limit_r <= line_supervision_pkg::LOOP_CURRENT_LIMIT_RESET;
    end
    else if (wr_en)
    begin
      unique case (reg_index)
        line_supervision_pkg::BATTERY_FEED_CONTROL_IDX:
          battery_feed_control_r <= pwdata[7:0] & line_supervision_pkg::BATTERY_FEED_CONTROL_MASK; // RULE_19
        line_supervision_pkg::AUTO_MANUAL_CONTROL_IDX:
          auto_manual_control_r <= pwdata[7:0] & line_supervision_pkg::AUTO_MANUAL_CONTROL_MASK; // RULE_19
        line_supervision_pkg::LOOP_CLOSURE_DEBOUNCE_IDX:
          loop_closure_debounce_r <= pwdata[6:0]; // RULE_15
        line_supervision_pkg::RING_TRIP_DEBOUNCE_IDX:
          ring_trip_debounce_r <= pwdata[6:0]; // RULE_16
        line_supervision_pkg::LOOP_CURRENT_LIMIT_IDX:
          loop_current_limit_r <= pwdata[2:0]; // RULE_17
        default:
        begin
        end
      endcase
    end
  end

  // raw comparator image, low while a threshold is exceeded
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      raw_detect_r <= 1'b0; // RULE_13
    end
    else
    begin
      raw_detect_r <= raw_detect_n; // RULE_11
    end
  end

  // the comparator serves ring trip while ringing and loop closure otherwise
  assign ringing = (linefeed_state_code == line_supervision_pkg::LINEFEED_RINGING);
  assign detected = ~raw_detect_n;

  detect_debounce #(
    .STEP_CYCLES(STEP_CYCLES)
  ) ring_trip_filter (
    .pclk(pclk),
    .presetn(presetn),
    .detect_raw(detected & ringing),
    .interval_code(ring_trip_debounce_r),
    .detect_filtered(ring_trip_filtered) // RULE_12
  );

  detect_debounce #(
    .STEP_CYCLES(STEP_CYCLES)
  ) loop_closure_filter (
    .pclk(pclk),
    .presetn(presetn),
    .detect_raw(detected & ~ringing),
    .interval_code(loop_closure_debounce_r),
    .detect_filtered(loop_closure_filtered) // RULE_13
  );

  auto_linefeed auto_state (
    .pclk(pclk),
    .presetn(presetn),
    .ring_trip_filtered(ring_trip_filtered),
    .loop_closure_filtered(loop_closure_filtered),
    .power_alarm(power_alarm),
    .auto_ring_trip_active(auto_manual_control_r[line_supervision_pkg::AUTO_RING_TRIP_ACTIVE_POS]),
    .auto_loop_closure_active(auto_manual_control_r[line_supervision_pkg::AUTO_LOOP_CLOSURE_ACTIVE_POS]),
    .auto_power_alarm_open(auto_manual_control_r[line_supervision_pkg::AUTO_POWER_ALARM_OPEN_POS]),
    .linefeed_req(linefeed_req),
    .linefeed_req_code(linefeed_req_code)
  );

  always_comb
  begin
    detect_status = line_supervision_pkg::DETECT_STATUS_RESET;
    detect_status[line_supervision_pkg::RAW_DETECT_OUTPUT_POS] = raw_detect_r; // RULE_11
    detect_status[line_supervision_pkg::RING_TRIP_FILTERED_POS] = ring_trip_filtered; // RULE_12
    detect_status[line_supervision_pkg::LOOP_CLOSURE_FILTERED_POS] = loop_closure_filtered; // RULE_13
  end

  always_comb
  begin
    rd_value = 8'h00;
    unique case (reg_index)
      line_supervision_pkg::BATTERY_FEED_CONTROL_IDX: rd_value = battery_feed_control_r;
      line_supervision_pkg::AUTO_MANUAL_CONTROL_IDX: rd_value = auto_manual_control_r;
      line_supervision_pkg::DETECT_STATUS_IDX: rd_value = detect_status;
      line_supervision_pkg::LOOP_CLOSURE_DEBOUNCE_IDX: rd_value = {1'b0, loop_closure_debounce_r}; // RULE_19
      line_supervision_pkg::RING_TRIP_DEBOUNCE_IDX: rd_value = {1'b0, ring_trip_debounce_r}; // RULE_19
      line_supervision_pkg::LOOP_CURRENT_LIMIT_IDX: rd_value = {5'h00, loop_current_limit_r}; // RULE_19
      default: rd_value = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle; reading changes no state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (rd_setup)
    begin
      prdata <= addr_ok ? {24'h000000, rd_value} : 32'h00000000; // RULE_20
    end
  end

  assign overhead_range_select = battery_feed_control_r[line_supervision_pkg::OVERHEAD_RANGE_SELECT_POS];
  assign overhead_max_dv = overhead_range_select ? line_supervision_pkg::OVERHEAD_WIDE_MAX_DV
    : line_supervision_pkg::OVERHEAD_NARROW_MAX_DV; // RULE_01
  assign battery_manual_set = battery_feed_control_r[line_supervision_pkg::BATTERY_MANUAL_SET_POS]; // RULE_02
  assign battery_track_ring = battery_feed_control_r[line_supervision_pkg::CONVERTER_TRACK_POS]; // RULE_03
  assign common_mode_manual = auto_manual_control_r[line_supervision_pkg::COMMON_MODE_MANUAL_POS]; // RULE_04
  assign differential_manual = auto_manual_control_r[line_supervision_pkg::DIFFERENTIAL_MANUAL_POS]; // RULE_05
  assign speedup_enable = auto_manual_control_r[line_supervision_pkg::SPEEDUP_ENABLE_POS]; // RULE_06
  assign battery_low_select = auto_manual_control_r[line_supervision_pkg::AUTO_BATTERY_SELECT_POS]
    & (ring_trip_filtered | loop_closure_filtered); // RULE_07
  assign loop_closure_debounce_time = loop_closure_debounce_r;
  assign ring_trip_debounce_time = ring_trip_debounce_r;
  assign loop_current_code = loop_current_limit_r;
  assign loop_current_ma = line_supervision_pkg::LOOP_CURRENT_BASE_MA
    + 6'(loop_current_limit_r) * line_supervision_pkg::LOOP_CURRENT_STEP_MA; // RULE_17

endmodule

// ==== design/line_supervision_pkg.sv ====
package line_supervision_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] BATTERY_FEED_CONTROL_IDX = 8'h42;
  localparam logic [7:0] AUTO_MANUAL_CONTROL_IDX = 8'h43;
  localparam logic [7:0] DETECT_STATUS_IDX = 8'h44;
  localparam logic [7:0] LOOP_CLOSURE_DEBOUNCE_IDX = 8'h45;
  localparam logic [7:0] RING_TRIP_DEBOUNCE_IDX = 8'h46;
  localparam logic [7:0] LOOP_CURRENT_LIMIT_IDX = 8'h47;

  // battery_feed_control fields
  localparam int OVERHEAD_RANGE_SELECT_POS = 4;
  localparam int BATTERY_MANUAL_SET_POS = 3;
  localparam int CONVERTER_TRACK_POS = 0;
  localparam logic [7:0] BATTERY_FEED_CONTROL_MASK = 8'h19;
  localparam logic [7:0] BATTERY_FEED_CONTROL_RESET = 8'h00;

  // auto_manual_control fields
  localparam int COMMON_MODE_MANUAL_POS = 6;
  localparam int DIFFERENTIAL_MANUAL_POS = 5;
  localparam int SPEEDUP_ENABLE_POS = 4;
  localparam int AUTO_BATTERY_SELECT_POS = 3;
  localparam int AUTO_RING_TRIP_ACTIVE_POS = 2;
  localparam int AUTO_LOOP_CLOSURE_ACTIVE_POS = 1;
  localparam int AUTO_POWER_ALARM_OPEN_POS = 0;
  localparam logic [7:0] AUTO_MANUAL_CONTROL_MASK = 8'h7f;
  localparam logic [7:0] AUTO_MANUAL_CONTROL_RESET = 8'h00;

  // detect_status fields
  localparam int RAW_DETECT_OUTPUT_POS = 2;
  localparam int RING_TRIP_FILTERED_POS = 1;
  localparam int LOOP_CLOSURE_FILTERED_POS = 0;
  localparam logic [7:0] DETECT_STATUS_RESET = 8'h00;

  // debounce intervals and current limit
  localparam int DEBOUNCE_TIME_WIDTH = 7;
  localparam logic [6:0] LOOP_CLOSURE_DEBOUNCE_RESET = 7'h0a;
  localparam logic [6:0] RING_TRIP_DEBOUNCE_RESET = 7'h0a;
  localparam int LOOP_CURRENT_CODE_WIDTH = 3;
  localparam logic [2:0] LOOP_CURRENT_LIMIT_RESET = 3'h0;

  // analog scale figures reported to the feed circuits
  localparam logic [5:0] LOOP_CURRENT_BASE_MA = 6'h14;
  localparam logic [5:0] LOOP_CURRENT_STEP_MA = 6'h03;
  localparam logic [7:0] OVERHEAD_NARROW_MAX_DV = 8'h5a;
  localparam logic [7:0] OVERHEAD_WIDE_MAX_DV = 8'h87;

  // linefeed state codes
  localparam logic [2:0] LINEFEED_OPEN = 3'h0;
  localparam logic [2:0] LINEFEED_FORWARD_ACTIVE = 3'h1;
  localparam logic [2:0] LINEFEED_RINGING = 3'h4;

  // timing: one debounce step is 1.25 ms
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int DEBOUNCE_STEP_NS = 1250000;
  localparam int DEBOUNCE_STEP_CYCLES = DEBOUNCE_STEP_NS / CLOCK_PERIOD_NS;
  localparam int DEBOUNCE_COUNT_WIDTH = 24;

  function automatic logic [23:0] debounce_cycles(input logic [6:0] code, input int step_cycles);
    int product;
    product = int'(code) * step_cycles;
    return product[23:0];
  endfunction

endpackage

// ==== design/detect_debounce.sv ====
`timescale 1ns/100ps
module detect_debounce #(
  parameter int STEP_CYCLES = line_supervision_pkg::DEBOUNCE_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic detect_raw,
  input wire logic [6:0] interval_code,
  output logic detect_filtered
);

  logic [23:0] steady_cnt_r;
  logic [23:0] limit;

  assign limit = line_supervision_pkg::debounce_cycles(interval_code, STEP_CYCLES);

  // filtered value follows raw only after raw differs for the whole interval
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      steady_cnt_r <= 24'h000000;
      detect_filtered <= 1'b0;
    end
    else if (detect_raw == detect_filtered)
    begin
      steady_cnt_r <= 24'h000000;
    end
    else if (steady_cnt_r >= limit)
    begin
      detect_filtered <= detect_raw; // RULE_14
      steady_cnt_r <= 24'h000000;
    end
    else
    begin
      steady_cnt_r <= steady_cnt_r + 24'h000001;
    end
  end

endmodule

// ==== design/auto_linefeed.sv ====
`timescale 1ns/100ps
module auto_linefeed (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ring_trip_filtered,
  input wire logic loop_closure_filtered,
  input wire logic power_alarm,
  input wire logic auto_ring_trip_active,
  input wire logic auto_loop_closure_active,
  input wire logic auto_power_alarm_open,
  output logic linefeed_req,
  output logic [2:0] linefeed_req_code
);

  logic rt_prev_r;
  logic lc_prev_r;
  logic pa_prev_r;
  logic rt_rise;
  logic lc_rise;
  logic pa_rise;

  assign rt_rise = ring_trip_filtered & ~rt_prev_r;
  assign lc_rise = loop_closure_filtered & ~lc_prev_r;
  assign pa_rise = power_alarm & ~pa_prev_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rt_prev_r <= 1'b0;
      lc_prev_r <= 1'b0;
      pa_prev_r <= 1'b0;
    end
    else
    begin
      rt_prev_r <= ring_trip_filtered;
      lc_prev_r <= loop_closure_filtered;
      pa_prev_r <= power_alarm;
    end
  end

  // a power alarm wins over an off-hook event in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      linefeed_req <= 1'b0;
      linefeed_req_code <= line_supervision_pkg::LINEFEED_OPEN;
    end
    else if (pa_rise && auto_power_alarm_open)
    begin
      linefeed_req <= 1'b1; // RULE_10
      linefeed_req_code <= line_supervision_pkg::LINEFEED_OPEN; // RULE_18
    end
    else if ((rt_rise && auto_ring_trip_active) || (lc_rise && auto_loop_closure_active))
    begin
      linefeed_req <= 1'b1; // RULE_08 RULE_09
      linefeed_req_code <= line_supervision_pkg::LINEFEED_FORWARD_ACTIVE; // RULE_18
    end
    else
    begin
      linefeed_req <= 1'b0;
    end
  end

endmodule

// ==== dv/line_supervision_asserts.sv ====
`timescale 1ns/100ps
module line_supervision_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic raw_detect_n,
  input wire logic [2:0] linefeed_state_code,
  input wire logic power_alarm,
  input wire logic overhead_range_select,
  input wire logic [7:0] overhead_max_dv,
  input wire logic battery_low_select,
  input wire logic ring_trip_filtered,
  input wire logic loop_closure_filtered,
  input wire logic [2:0] loop_current_code,
  input wire logic [5:0] loop_current_ma,
  input wire logic linefeed_req,
  input wire logic [2:0] linefeed_req_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_overhead_range_max: assert property (overhead_max_dv == (overhead_range_select ? 8'h87 : 8'h5a))
    else $error("overhead limit does not follow range bit");
  a_current_ma_scale: assert property (loop_current_ma == 6'h14 + 6'h03 * {3'h0, loop_current_code})
    else $error("loop current does not follow code");
  a_low_battery_offhook: assert property (battery_low_select |-> (ring_trip_filtered || loop_closure_filtered))
    else $error("low battery chosen while on hook");
  a_req_target_code: assert property (linefeed_req |-> linefeed_req_code inside {3'h0, 3'h1})
    else $error("automatic target code illegal");
  a_loop_rise_cause: assert property ($rose(loop_closure_filtered) |-> !$past(raw_detect_n) && $past(linefeed_state_code) != 3'h4)
    else $error("loop closure indication without detection");
  a_ring_rise_cause: assert property ($rose(ring_trip_filtered) |-> !$past(raw_detect_n) && $past(linefeed_state_code) == 3'h4)
    else $error("ring trip indication without detection");
  a_open_after_alarm: assert property (linefeed_req && linefeed_req_code == 3'h0 |-> $past(power_alarm))
    else $error("open request without power alarm");
  a_active_after_detect: assert property (linefeed_req && linefeed_req_code == 3'h1 |-> $past(ring_trip_filtered || loop_closure_filtered))
    else $error("active request without detection");
  a_upper_read_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_error_in_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");

  c_req: cover property (linefeed_req);
  c_ring: cover property ($rose(ring_trip_filtered));
  c_loop: cover property ($rose(loop_closure_filtered));
  c_err: cover property (pslverr);
endmodule

bind line_supervision_control line_supervision_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pslverr(pslverr), .raw_detect_n(raw_detect_n),
  .linefeed_state_code(linefeed_state_code), .power_alarm(power_alarm), .overhead_range_select(overhead_range_select),
  .overhead_max_dv(overhead_max_dv), .battery_low_select(battery_low_select), .ring_trip_filtered(ring_trip_filtered),
  .loop_closure_filtered(loop_closure_filtered), .loop_current_code(loop_current_code),
  .loop_current_ma(loop_current_ma), .linefeed_req(linefeed_req), .linefeed_req_code(linefeed_req_code));

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, raw_detect_n = 1, power_alarm = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic err;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] linefeed_state_code = 3'h1;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ors, bms, btr, cmm, dfm, spd, bls, rtf, lcf, lreq;
  wire logic [7:0] omax;
  wire logic [6:0] lcdt, rtdt;
  wire logic [2:0] lcc, lrc;
  wire logic [5:0] lma;
  int n_errors = 0, total_checks = 0, i;
  logic [7:0] idx [6] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
  // status shows the raw bit high once reset is gone and no threshold is exceeded
  logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h04, 8'h0a, 8'h0a, 8'h00};
  logic [7:0] ones_val [6] = '{8'h19, 8'h7f, 8'h04, 8'h7f, 8'h7f, 8'h07};

  line_supervision_control #(.STEP_CYCLES(4)) u_line_supervision_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_detect_n(raw_detect_n),
    .linefeed_state_code(linefeed_state_code), .power_alarm(power_alarm), .overhead_range_select(ors),
    .overhead_max_dv(omax), .battery_manual_set(bms), .battery_track_ring(btr), .common_mode_manual(cmm),
    .differential_manual(dfm), .speedup_enable(spd), .battery_low_select(bls), .ring_trip_filtered(rtf),
    .loop_closure_filtered(lcf), .loop_closure_debounce_time(lcdt), .ring_trip_debounce_time(rtdt),
    .loop_current_code(lcc), .loop_current_ma(lma), .linefeed_req(lreq), .linefeed_req_code(lrc));

  always #5 pclk = ~pclk;

  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] ix, input logic [31:0] d, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_cycles(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    report_and_stop;
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      apb(1'b0, idx[i], 32'h0, 4'hf);
      check(rd, {24'h0, rst_val[i]});
    end
    check({omax, 2'b00, lma}, {8'h5a, 8'h14});
    $display("test reset_values done");
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, idx[i], 32'hffffffff, 4'hf);
      apb(1'b0, idx[i], 32'h0, 4'hf);
      check(rd, {24'h0, ones_val[i]});
      check(err, 1'b0);
    end
    check({ors, bms, btr, omax}, {3'b111, 8'h87});
    check({cmm, dfm, spd}, 3'b111);
    check({lcdt, rtdt}, 14'h3fff);
    apb(1'b1, 8'h45, 32'h0, 4'he);
    apb(1'b0, 8'h45, 32'h0, 4'hf);
    check(rd, 32'h7f);
    apb(1'b0, 8'h48, 32'h0, 4'hf);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("test access_kinds done");
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, 8'h47, i, 4'hf);
      wait_cycles(1);
      check(lma, 6'h14 + 6'h03 * i[5:0]);
      check(lcc, i);
    end
    $display("test current_scale done");
    apb(1'b1, 8'h42, 32'h0, 4'hf);
    apb(1'b1, 8'h43, 32'h0e, 4'hf);
    apb(1'b1, 8'h45, 32'h02, 4'hf);
    apb(1'b1, 8'h46, 32'h01, 4'hf);
    raw_detect_n <= 1'b0;
    wait_cycles(5);
    raw_detect_n <= 1'b1;
    wait_cycles(12);
    check(lcf, 1'b0);
    raw_detect_n <= 1'b0;
    wait_cycles(6);
    check(lcf, 1'b0);
    for (i = 0; i < 20 && lcf !== 1'b1; i++)
      wait_cycles(1);
    check(lcf, 1'b1);
    wait_cycles(1);
    check({lreq, lrc}, 4'b1001);
    apb(1'b0, 8'h44, 32'h0, 4'hf);
    check(rd, 32'h01);
    apb(1'b0, 8'h44, 32'h0, 4'hf);
    check(rd, 32'h01);
    check(bls, 1'b1);
    $display("test loop_closure done");
    linefeed_state_code <= 3'h4;
    for (i = 0; i < 30 && rtf !== 1'b1; i++)
      wait_cycles(1);
    check(rtf, 1'b1);
    wait_cycles(1);
    check({lreq, lrc}, 4'b1001);
    wait_cycles(20);
    apb(1'b0, 8'h44, 32'h0, 4'hf);
    check(rd, 32'h02);
    raw_detect_n <= 1'b1;
    wait_cycles(20);
    apb(1'b0, 8'h44, 32'h0, 4'hf);
    check(rd, 32'h04);
    check(bls, 1'b0);
    $display("test ring_trip done");
    apb(1'b1, 8'h43, 32'h01, 4'hf);
    power_alarm <= 1'b1;
    for (i = 0; i < 5 && lreq !== 1'b1; i++)
      wait_cycles(1);
    check({lreq, lrc}, 4'b1000);
    power_alarm <= 1'b0;
    $display("test power_alarm done");
    report_and_stop;
  end
endmodule
